// File: core/tmr_ext_pkg.sv
// package: register map, field positions and carrier types for the external pin block
package tmr_ext_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_EXT_PIN_CONTROL = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_EXT_EVENT_STATUS = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE_VALUE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_COUNTER_VALUE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_EXT_IRQ_MASK = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_COUNT_MODE = 8'h20;
  localparam logic [31:0] RST_EXT_PIN_CONTROL = 32'h00000000;
  localparam logic [31:0] RST_EXT_EVENT_STATUS = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  localparam int CTL_W = 8;
  localparam int CNT_W = 24;
  localparam int DB_STABLE = 4;
  localparam int BIT_COUNT_PHASE = 0;
  localparam int BIT_EDGE_LO = 1;
  localparam int BIT_TRIG_EN = 3;
  localparam int BIT_ACTION = 4;
  localparam int BIT_IRQ_EN = 5;
  localparam int BIT_TRIG_DB = 6;
  localparam int BIT_CNT_DB = 7;
  localparam int BIT_FLAG = 0;
  localparam int BIT_COUNT_MODE = 0;

  // edge select encodings
  typedef enum logic [1:0] {
    EDGE_FALL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_BOTH = 2'h2,
    EDGE_RSVD = 2'h3
  } edge_sel_t;

  // decoded control register
  typedef struct packed {
    logic count_pin_debounce_en;
    logic trigger_pin_debounce_en;
    logic ext_irq_enable;
    logic trigger_action_select;
    logic trigger_pin_enable;
    edge_sel_t trigger_edge_select;
    logic count_phase;
  } ctl_t;

  // avalon request bundle
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } av_req_t;

  // synchroniser plus debounce state of one pin
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev_raw;
    logic level;
    logic [2:0] stable_cnt;
    logic prev_out;
  } pin_state_t;
endpackage

// File: core/tmr_ext_pin_cond.sv
// module: pin synchroniser, optional debounce and edge detector
`timescale 1ns/100ps
module tmr_ext_pin_cond
  import tmr_ext_pkg::*;
#(
  parameter int STABLE = DB_STABLE
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic debounce_en_i,
  output logic rise_o,
  output logic fall_o,
  output logic level_o
);
  pin_state_t st_q; // all state
  pin_state_t st_d; // next state
  logic cur; // level seen by edge detector

  // two-flop sync, then filter that needs STABLE equal samples
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
    st_d.prev_raw = st_q.s2;
    if (st_q.s2 != st_q.prev_raw) begin
      st_d.stable_cnt = 3'h0;
    end else if (st_q.stable_cnt < 3'(STABLE - 1)) begin
      st_d.stable_cnt = st_q.stable_cnt + 3'h1;
    end else begin
      st_d.level = st_q.s2;
    end
    // bypass still uses the synced level, so switching debounce glitches only while level and s2 differ
    cur = debounce_en_i ? st_q.level : st_q.s2;
    st_d.prev_out = cur;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // edges compare against last cycle's chosen level
  assign rise_o = cur & ~st_q.prev_out;
  assign fall_o = ~cur & st_q.prev_out;
  assign level_o = cur;

  AST_SYNC_TWO_FLOPS: assert property (@(posedge clk_i) disable iff (rst_i)
    !debounce_en_i && $changed(pin_i) ##1 !debounce_en_i && $stable(pin_i) |=> !debounce_en_i || level_o == $past(pin_i, 2))
    else $error("sync path latency wrong");
endmodule

// File: core/tmr_ext_pin_capture.sv
// module: external trigger and count pin logic of one timer with avalon registers
`timescale 1ns/100ps
// Function
// - count pin debounce when its enable set
// - trigger pin debounce when its enable set
// - selected trigger edge raises irq when enabled and the irq mask is set
// - action select: 1 resets counter, 0 captures
// - trigger pin ignored unless enabled
// - edge field: fall, rise, both, reserved
// - count phase picks counted count-pin edge
// - enabled matching trigger edge sets event flag
// - writing one clears the event flag
// - capture loads 24-bit counter on trigger
// - event count mode counts count-pin edges
module tmr_ext_pin_capture
  import tmr_ext_pkg::*;
#(
  parameter int STABLE = DB_STABLE
) (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic TRIGGER_PIN_I,
  input wire logic COUNT_PIN_I,
  input wire logic TICK_I,
  output logic [CNT_W-1:0] COUNTER_VALUE_O,
  output logic [CNT_W-1:0] CAPTURE_VALUE_O,
  output logic EXT_IRQ_O
);
  // whole block state
  typedef struct packed {
    ctl_t ctl;
    logic ext_event_flag;
    logic irq_mask;
    logic event_count_mode;
    logic [CNT_W-1:0] counter_value;
    logic [CNT_W-1:0] capture_value;
    logic ack;
    logic [31:0] rdata;
  } blk_state_t;

  blk_state_t st_q; // registered state
  blk_state_t st_d; // next state
  av_req_t req; // bundled bus request
  logic trig_rise; // trigger pin edges
  logic trig_fall;
  logic cnt_rise; // count pin edges
  logic cnt_fall;
  logic trig_hit; // enabled, matching trigger edge
  logic cnt_hit; // counted count-pin edge
  logic wr_acc; // write taken this cycle
  logic rd_acc; // read taken this cycle
  logic [31:0] rd_mux; // read data before register

  assign req = '{address: AVS_ADDRESS_I, read: AVS_READ_I, write: AVS_WRITE_I,
                 writedata: AVS_WRITEDATA_I, byteenable: AVS_BYTEENABLE_I};

  // trigger pin conditioning
  tmr_ext_pin_cond #(.STABLE(STABLE)) u_trig (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .pin_i(TRIGGER_PIN_I),
    .debounce_en_i(st_q.ctl.trigger_pin_debounce_en),
    .rise_o(trig_rise),
    .fall_o(trig_fall),
    .level_o()
  );

  // count pin conditioning
  tmr_ext_pin_cond #(.STABLE(STABLE)) u_cnt (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .pin_i(COUNT_PIN_I),
    .debounce_en_i(st_q.ctl.count_pin_debounce_en),
    .rise_o(cnt_rise),
    .fall_o(cnt_fall),
    .level_o()
  );

  // edge decode and gating
  always_comb begin
    case (st_q.ctl.trigger_edge_select)
      EDGE_FALL: trig_hit = trig_fall;
      EDGE_RISE: trig_hit = trig_rise;
      EDGE_BOTH: trig_hit = trig_rise | trig_fall;
      default: trig_hit = 1'b0; // reserved code detects nothing
    endcase
    trig_hit = trig_hit & st_q.ctl.trigger_pin_enable;
    cnt_hit = st_q.ctl.count_phase ? cnt_rise : cnt_fall;
  end

  // one wait state: ack comes the cycle after the request
  assign wr_acc = req.write & st_q.ack;
  assign rd_acc = req.read & st_q.ack;
  assign AVS_WAITREQUEST_O = (req.read | req.write) & ~st_q.ack;

  // read mux
  always_comb begin
    case (req.address)
      OFF_EXT_PIN_CONTROL: rd_mux = {24'h000000, st_q.ctl};
      OFF_EXT_EVENT_STATUS: rd_mux = {31'h00000000, st_q.ext_event_flag};
      OFF_EXT_IRQ_MASK: rd_mux = {31'h00000000, st_q.irq_mask};
      OFF_COUNT_MODE: rd_mux = {31'h00000000, st_q.event_count_mode};
      OFF_COUNTER_VALUE: rd_mux = {8'h00, st_q.counter_value};
      OFF_CAPTURE_VALUE: rd_mux = {8'h00, st_q.capture_value};
      default: rd_mux = UNMAPPED_READ;
    endcase
  end

  // next state
  always_comb begin
    st_d = st_q;
    st_d.ack = (req.read | req.write) & ~st_q.ack;
    st_d.rdata = st_q.ack ? st_q.rdata : rd_mux;
    // writes; only the low byte lane holds live bits
    if (wr_acc && req.byteenable[0]) begin
      case (req.address)
        OFF_EXT_PIN_CONTROL: st_d.ctl = ctl_t'(req.writedata[CTL_W-1:0]);
        OFF_EXT_IRQ_MASK: st_d.irq_mask = req.writedata[0];
        OFF_COUNT_MODE: st_d.event_count_mode = req.writedata[BIT_COUNT_MODE];
        OFF_EXT_EVENT_STATUS: begin
          if (req.writedata[BIT_FLAG]) begin
            st_d.ext_event_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // hardware set wins over a same-cycle clear
    if (trig_hit) begin
      st_d.ext_event_flag = 1'b1;
    end
    // counter: external events or prescaled ticks
    if (st_q.event_count_mode ? cnt_hit : TICK_I) begin
      st_d.counter_value = st_q.counter_value + 24'h000001;
    end
    if (trig_hit) begin
      if (st_q.ctl.trigger_action_select) begin
        st_d.counter_value = '0;
      end else begin
        st_d.capture_value = st_q.counter_value;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      st_q <= '0;
      st_q.ctl <= ctl_t'(RST_EXT_PIN_CONTROL[CTL_W-1:0]);
      st_q.ext_event_flag <= RST_EXT_EVENT_STATUS[BIT_FLAG];
      st_q.irq_mask <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // flag gated by enable bit and mask
  assign EXT_IRQ_O = st_q.ext_event_flag & st_q.ctl.ext_irq_enable & st_q.irq_mask;
  assign AVS_READDATA_O = st_q.rdata;
  assign COUNTER_VALUE_O = st_q.counter_value;
  assign CAPTURE_VALUE_O = st_q.capture_value;

  // checks
  AST_EDGE_SETS_FLAG: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    trig_hit |=> st_q.ext_event_flag)
    else $error("flag not set by trigger edge");
  AST_DISABLED_IGNORED: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !st_q.ctl.trigger_pin_enable && !st_q.ext_event_flag && !wr_acc |=> !st_q.ext_event_flag)
    else $error("disabled trigger set flag");
  AST_RESERVED_EDGE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    st_q.ctl.trigger_edge_select == EDGE_RSVD |-> !trig_hit)
    else $error("reserved edge code detected an edge");
  AST_W1C: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    wr_acc && req.address == OFF_EXT_EVENT_STATUS && req.byteenable[0] && req.writedata[0] && !trig_hit
    |=> !st_q.ext_event_flag)
    else $error("write one did not clear flag");
  AST_W0_KEEPS: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    wr_acc && req.address == OFF_EXT_EVENT_STATUS && !req.writedata[0] && st_q.ext_event_flag
    |=> st_q.ext_event_flag)
    else $error("write zero changed flag");
  AST_IRQ: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    trig_hit && st_q.ctl.ext_irq_enable && st_q.irq_mask && !wr_acc |=> EXT_IRQ_O)
    else $error("irq not raised");
  AST_IRQ_OFF: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    !st_q.ctl.ext_irq_enable |-> !EXT_IRQ_O)
    else $error("irq raised while disabled");
  AST_CAPTURE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    trig_hit && !st_q.ctl.trigger_action_select |=> CAPTURE_VALUE_O == $past(st_q.counter_value))
    else $error("capture value wrong");
  AST_RESET_MODE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    trig_hit && st_q.ctl.trigger_action_select |=> COUNTER_VALUE_O == 24'h000000)
    else $error("counter not cleared");
  AST_EVENT_COUNT: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    st_q.event_count_mode && cnt_hit && !trig_hit |=> COUNTER_VALUE_O == $past(st_q.counter_value) + 24'h000001)
    else $error("event count missed");
  AST_PHASE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    st_q.ctl.count_phase && cnt_fall |-> !cnt_hit)
    else $error("wrong count phase");
  AST_WAIT_ONE: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
    $rose(AVS_READ_I) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
    else $error("wait state count wrong");

  COV_CAPTURE: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    trig_hit && !st_q.ctl.trigger_action_select);
  COV_RESET: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    trig_hit && st_q.ctl.trigger_action_select);
  COV_IRQ_CLEAR: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    EXT_IRQ_O ##[1:20] !EXT_IRQ_O);
  COV_EVENT_COUNT: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
    st_q.event_count_mode && cnt_hit);
endmodule

// File: test/tmr_ext_pin_model.sv
// board side model: drives trigger and count pins, with an optional short spike
`timescale 1ns/100ps
module tmr_ext_pin_model (
  input wire logic clk_i,
  input wire logic trig_lvl_i,
  input wire logic cnt_lvl_i,
  input wire logic glitch_i,
  output logic trig_o,
  output logic cnt_o
);
  logic [1:0] spike_q = 2'h0; // spike cycles left
  // spike is only two clocks: too short to pass a debounce filter
  always_ff @(posedge clk_i) begin
    if (glitch_i && spike_q == 2'h0) spike_q <= 2'h2;
    else if (spike_q != 2'h0) spike_q <= spike_q - 2'h1;
  end
  // pins follow requested levels, inverted during a spike
  assign trig_o = trig_lvl_i ^ (spike_q != 2'h0);
  assign cnt_o = cnt_lvl_i ^ (spike_q != 2'h0);
endmodule

// File: test/timer_external_pin_capture_reset_tb_top.sv
// self-checking bench of the external pin block with the board pin model
`timescale 1ns/100ps
module timer_external_pin_capture_reset_tb_top;
  import tmr_ext_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic tick = 1'b0;
  logic trig_lvl = 1'b0;
  logic cnt_lvl = 1'b0;
  logic glitch = 1'b0;
  logic [3:0] be = 4'hF;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq, irq, trig_pin, cnt_pin;
  logic [CNT_W-1:0] cnt_val, cap_val;
  int miscompares = 0;
  int cmp_count = 0;
  logic [15:0] seed = 16'hD76E; // fixed seed
  logic [23:0] exp_cnt = 24'h0; // bench copy of the counter
  logic [23:0] cap_exp;

  tmr_ext_pin_capture #(.STABLE(4)) DUT (.CLK_SYS_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .TRIGGER_PIN_I(trig_pin),
    .COUNT_PIN_I(cnt_pin), .TICK_I(tick), .COUNTER_VALUE_O(cnt_val), .CAPTURE_VALUE_O(cap_val),
    .EXT_IRQ_O(irq));
  tmr_ext_pin_model board (.clk_i(clk), .trig_lvl_i(trig_lvl), .cnt_lvl_i(cnt_lvl),
    .glitch_i(glitch), .trig_o(trig_pin), .cnt_o(cnt_pin));

  // 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end

  // galois lfsr step, then a value in 1..n
  function automatic int rnd(input int n);
    seed = {1'b0, seed[15:1]} ^ (seed[0] ? 16'hB400 : 16'h0);
    return 1 + (seed % n);
  endfunction

  // does edge code c report this pin edge
  function automatic logic hit(input logic [1:0] c, input logic rise);
    return (c == 2'h2) || (c == 2'h1 && rise) || (c == 2'h0 && !rise);
  endfunction

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one access; request held until waitrequest seen low, bounded wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    rd_en <= ~w;
    wr_en <= w;
    // waitrequest and read data are looked at on the rising edge only
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    // one idle edge, so the next call never re-raises a strobe in this step
    @(posedge clk);
    if (n >= 50) begin
      miscompares++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  // flag via register, irq straight from the pin
  task automatic stat(input logic f, input logic i);
    chk({31'h0, irq}, {31'h0, i});
    rd(OFF_EXT_EVENT_STATUS, {31'h0, f});
  endtask

  // move a pin, then wait out sync and filter latency
  task automatic move(input logic t, input logic v);
    if (t) trig_lvl <= v;
    else cnt_lvl <= v;
    repeat (12) @(posedge clk);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      @(posedge clk);
      exp_cnt++;
    end
  endtask

  task automatic spike();
    glitch <= 1'b1;
    @(posedge clk);
    glitch <= 1'b0;
    repeat (12) @(posedge clk);
  endtask

  task automatic cnt_is();
    chk({8'h0, cnt_val}, {8'h0, exp_cnt});
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values, unmapped place, masked-off write
    rd(OFF_EXT_PIN_CONTROL, RST_EXT_PIN_CONTROL);
    rd(OFF_EXT_EVENT_STATUS, RST_EXT_EVENT_STATUS);
    rd(OFF_EXT_IRQ_MASK, 32'h1);
    rd(OFF_COUNT_MODE, 32'h0);
    rd(8'h04, UNMAPPED_READ);
    wr(OFF_EXT_PIN_CONTROL, 32'hFFFFFF3A);
    rd(OFF_EXT_PIN_CONTROL, 32'h3A);
    be <= 4'hE;
    wr(OFF_EXT_PIN_CONTROL, 32'h0);
    be <= 4'hF;
    rd(OFF_EXT_PIN_CONTROL, 32'h3A);
    // every edge code, both pin directions, w1c with zero then one
    for (int c = 0; c < 4; c++) begin
      wr(OFF_EXT_PIN_CONTROL, 32'h28 | (c << 1));
      move(1'b1, 1'b1);
      stat(hit(c[1:0], 1'b1), hit(c[1:0], 1'b1));
      wr(OFF_EXT_EVENT_STATUS, 32'h1);
      move(1'b1, 1'b0);
      stat(hit(c[1:0], 1'b0), hit(c[1:0], 1'b0));
      wr(OFF_EXT_EVENT_STATUS, 32'h0);
      rd(OFF_EXT_EVENT_STATUS, {31'h0, hit(c[1:0], 1'b0)});
      wr(OFF_EXT_EVENT_STATUS, 32'h1);
    end
    // capture after random ticks
    ticks(rnd(15));
    cnt_is();
    wr(OFF_EXT_PIN_CONTROL, 32'h0C);
    move(1'b1, 1'b1);
    chk({8'h0, cap_val}, {8'h0, exp_cnt});
    stat(1'b1, 1'b0);
    // counter reset, capture left alone, counting resumes
    cap_exp = exp_cnt;
    ticks(rnd(15));
    wr(OFF_EXT_PIN_CONTROL, 32'h1C);
    move(1'b1, 1'b0);
    exp_cnt = 24'h0;
    cnt_is();
    chk({8'h0, cap_val}, {8'h0, cap_exp});
    ticks(3);
    cnt_is();
    // pin disabled: no reset, no flag
    wr(OFF_EXT_PIN_CONTROL, 32'h34);
    wr(OFF_EXT_EVENT_STATUS, 32'h1);
    move(1'b1, 1'b1);
    cnt_is();
    stat(1'b0, 1'b0);
    // mask and enable gate the irq, flag stays
    wr(OFF_EXT_IRQ_MASK, 32'h0);
    wr(OFF_EXT_PIN_CONTROL, 32'h2C);
    move(1'b1, 1'b0);
    stat(1'b1, 1'b0);
    wr(OFF_EXT_IRQ_MASK, 32'h1);
    stat(1'b1, 1'b1);
    wr(OFF_EXT_PIN_CONTROL, 32'h0C);
    stat(1'b1, 1'b0);
    wr(OFF_EXT_EVENT_STATUS, 32'h1);
    // event count mode: ticks ignored, phase picks the edge
    wr(OFF_COUNT_MODE, 32'h1);
    ticks(2);
    exp_cnt -= 24'h2;
    for (int p = 1; p >= 0; p--) begin
      wr(OFF_EXT_PIN_CONTROL, p);
      move(1'b0, 1'b1);
      exp_cnt += {23'h0, p[0]};
      cnt_is();
      move(1'b0, 1'b0);
      exp_cnt += {23'h0, !p[0]};
      cnt_is();
    end
    repeat (rnd(6)) begin
      move(1'b0, 1'b1);
      move(1'b0, 1'b0);
      exp_cnt++;
    end
    cnt_is();
    // short spike: dropped with filters, seen without
    wr(OFF_EXT_PIN_CONTROL, 32'hCD);
    spike();
    cnt_is();
    stat(1'b0, 1'b0);
    wr(OFF_EXT_PIN_CONTROL, 32'h0D);
    spike();
    exp_cnt++;
    cnt_is();
    stat(1'b1, 1'b0);
    give_verdict();
  end
endmodule
